/* core/rcc_pkg.sv */
package rcc_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_CTRL_STAT = 32'h4000_0200;
    localparam logic [31:0] ADDR_EM_BASE   = 32'h4000_0208;
    localparam logic [31:0] ADDR_EVT_STAT  = 32'h4000_0220;
    localparam logic [31:0] ADDR_EVT_MASK  = 32'h4000_0224;
    localparam logic [31:0] ADDR_SLEEP_CTL = 32'h4000_0228;
    localparam logic [31:0] ADDR_DIAG_VAL  = 32'h4000_022c;

    // control/status register bit positions
    localparam int CS_PERMIT   = 8;
    localparam int CS_LP_SEEN  = 7;
    localparam int CS_CLK_SRC  = 6;
    localparam int CS_DIAG_OVR = 3;
    localparam int CS_ERR_MSK  = 2;
    localparam int CS_ERR_ACK  = 1;
    localparam int CS_ERR_FLAG = 0;

    // exchange memory base field
    localparam int EMB_LSB = 10;
    localparam int EMB_MSB = 16;
    localparam int EMB_W   = 7;

    // event status / mask bit positions
    localparam int EVT_ERR    = 0;
    localparam int EVT_LP     = 1;
    localparam int EVT_PERMIT = 2;
    localparam int EVT_WAKE   = 3;
    localparam int EVT_W      = 4;

    // sleep control bit position
    localparam int SLP_ON = 0;

    // widths
    localparam int DIAG_W = 8;
    localparam int PAGE_W = 6;
    localparam int CNT_W  = 4;

    // reset values
    localparam logic               ERR_MSK_RST  = 1'b1;
    localparam logic [EMB_W-1:0]   EMB_RST      = 7'h00;
    localparam logic [EVT_W-1:0]   EVT_MASK_RST = 4'h0;
    localparam logic [DIAG_W-1:0]  DIAG_VAL_RST = 8'h00;

    // low-power clock edges counted before power-down is permitted
    localparam logic [CNT_W-1:0]   PD_LP_EDGES  = 4'h2;

    typedef enum logic [1:0] {
        RCC_SLP_IDLE,
        RCC_SLP_COUNT,
        RCC_SLP_PERMIT
    } rcc_slp_state_t;

endpackage

/* core/rcc_lp_edge.sv */
`timescale 1ns/1ps
module rcc_lp_edge (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // low-power clock sample and edge pulse
    input  wire logic lp_clk,
    output logic      lp_edge
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } rcc_edge_st_t;

    rcc_edge_st_t st_r;
    rcc_edge_st_t st_nxt;

    // two-flop synchroniser, third flop only for edge detection
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = lp_clk;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // all ones: a pin already high at release gives no false edge
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lp_edge = st_r.s2 & ~st_r.s3;

endmodule

/* core/rcc_top.sv */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Contract
// (R1) deep sleep request leads to power-down permit
// (R2) sleep exit interrupt clears power-down permit
// (R3) low-power clock rising edge sets monitor flag
// (R4) software write zero clears monitor, one ignored
// (R5) no monitor set while lp timer reset
// (R6) status bit shows core clock source
// (R7) override bit overrules diagnostic port output
// (R8) error mask resets one, zero blocks irq
// (R9) error irq level while flag and mask
// (R10) acknowledge write one clears flag, reads zero
// (R11) unmapped page access sets error flag
// (R12) base field bits 16:10 give base address
// (R13) reserved bits read zero, ignore writes
module rcc_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core status inputs
    input  wire logic        lp_clk,
    input  wire logic        lp_timer_reset,
    input  wire logic        core_clock_source_stat,
    input  wire logic        sleep_exit_irq,
    // exchange memory access monitor
    input  wire logic        em_acc_valid,
    input  wire logic [5:0]  em_acc_page,
    input  wire logic [5:0]  em_page_map,
    // diagnostic port
    input  wire logic [7:0]  core_diag_port,
    output logic      [7:0]  diag_out,
    // outputs to the core and system
    output logic             powerdown_permit,
    output logic             core_error_irq,
    output logic             irq,
    output logic      [31:0] exchange_mem_base_addr
);

    typedef struct packed {
        rcc_pkg::rcc_slp_state_t              slp;
        logic [rcc_pkg::CNT_W-1:0]            lp_cnt;
        logic                                 permit;
        logic                                 deep_sleep_on;
        logic                                 lp_seen;
        logic                                 clk_src;
        logic                                 diag_ovr;
        logic                                 err_mask;
        logic                                 err_flag;
        logic                                 err_irq;
        logic [rcc_pkg::EMB_W-1:0]            em_base;
        logic [rcc_pkg::EVT_W-1:0]            evt_stat;
        logic [rcc_pkg::EVT_W-1:0]            evt_mask;
        logic                                 irq;
        logic [rcc_pkg::DIAG_W-1:0]           diag_val;
        logic [rcc_pkg::DIAG_W-1:0]           diag_out;
        logic                                 pready;
        logic                                 pslverr;
        logic [31:0]                          prdata;
    } rcc_st_t;

    localparam rcc_st_t ST_RST = '{
        slp:           rcc_pkg::RCC_SLP_IDLE,
        lp_cnt:        '0,
        permit:        1'b0,
        deep_sleep_on: 1'b0,
        lp_seen:       1'b0,
        clk_src:       1'b0,
        diag_ovr:      1'b0,
        err_mask:      rcc_pkg::ERR_MSK_RST,
        err_flag:      1'b0,
        err_irq:       1'b0,
        em_base:       rcc_pkg::EMB_RST,
        evt_stat:      '0,
        evt_mask:      rcc_pkg::EVT_MASK_RST,
        irq:           1'b0,
        diag_val:      rcc_pkg::DIAG_VAL_RST,
        diag_out:      '0,
        pready:        1'b0,
        pslverr:       1'b0,
        prdata:        32'h0000_0000
    };

    rcc_st_t                      st_r;
    rcc_st_t                      st_nxt;
    logic                         lp_edge;
    logic                         lp_set;
    logic                         err_event;
    logic                         access;
    logic                         wr_done;
    logic                         hit;
    logic [31:0]                  rd;
    logic [rcc_pkg::CNT_W-1:0]    cnt_inc;
    logic [rcc_pkg::EVT_W-1:0]    evt;

    rcc_lp_edge u_lp_edge (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .lp_clk   (lp_clk),
        .lp_edge  (lp_edge)
    );

    assign lp_set    = lp_edge & ~lp_timer_reset; // R3 R5
    assign err_event = em_acc_valid & (em_acc_page > em_page_map); // R11
    assign access    = psel & penable;
    assign wr_done   = access & st_r.pready & pwrite & hit;
    assign cnt_inc   = st_r.lp_cnt + 4'h1;

    // read mux and address decode
    always_comb begin
        rd  = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            rcc_pkg::ADDR_CTRL_STAT: begin
                rd[rcc_pkg::CS_PERMIT]   = st_r.permit;
                rd[rcc_pkg::CS_LP_SEEN]  = st_r.lp_seen;
                rd[rcc_pkg::CS_CLK_SRC]  = st_r.clk_src; // R6
                rd[rcc_pkg::CS_DIAG_OVR] = st_r.diag_ovr;
                rd[rcc_pkg::CS_ERR_MSK]  = st_r.err_mask;
                rd[rcc_pkg::CS_ERR_FLAG] = st_r.err_flag; // R10 R13
            end
            rcc_pkg::ADDR_EM_BASE: begin
                rd[rcc_pkg::EMB_MSB:rcc_pkg::EMB_LSB] = st_r.em_base; // R13
            end
            rcc_pkg::ADDR_EVT_STAT: begin
                rd[rcc_pkg::EVT_W-1:0] = st_r.evt_stat;
            end
            rcc_pkg::ADDR_EVT_MASK: begin
                rd[rcc_pkg::EVT_W-1:0] = st_r.evt_mask;
            end
            rcc_pkg::ADDR_SLEEP_CTL: begin
                rd[rcc_pkg::SLP_ON] = st_r.deep_sleep_on;
            end
            rcc_pkg::ADDR_DIAG_VAL: begin
                rd[rcc_pkg::DIAG_W-1:0] = st_r.diag_val;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        evt    = '0;

        // apb: one wait state, answer registered
        if (access && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd;
            st_nxt.pslverr = ~hit;
        end else begin
            st_nxt.pready  = 1'b0;
            st_nxt.prdata  = 32'h0000_0000;
            st_nxt.pslverr = 1'b0;
        end

        // software writes, taken at completion edge
        if (wr_done) begin
            case (paddr)
                rcc_pkg::ADDR_CTRL_STAT: begin
                    if (!pwdata[rcc_pkg::CS_LP_SEEN]) begin
                        st_nxt.lp_seen = 1'b0; // R4
                    end
                    st_nxt.diag_ovr = pwdata[rcc_pkg::CS_DIAG_OVR]; // R7
                    st_nxt.err_mask = pwdata[rcc_pkg::CS_ERR_MSK]; // R8
                    if (pwdata[rcc_pkg::CS_ERR_ACK]) begin
                        st_nxt.err_flag = 1'b0; // R10
                    end
                end
                rcc_pkg::ADDR_EM_BASE: begin
                    st_nxt.em_base = pwdata[rcc_pkg::EMB_MSB:rcc_pkg::EMB_LSB]; // R12
                end
                rcc_pkg::ADDR_EVT_STAT: begin
                    st_nxt.evt_stat = st_r.evt_stat & ~pwdata[rcc_pkg::EVT_W-1:0];
                end
                rcc_pkg::ADDR_EVT_MASK: begin
                    st_nxt.evt_mask = pwdata[rcc_pkg::EVT_W-1:0];
                end
                rcc_pkg::ADDR_SLEEP_CTL: begin
                    st_nxt.deep_sleep_on = pwdata[rcc_pkg::SLP_ON];
                end
                rcc_pkg::ADDR_DIAG_VAL: begin
                    st_nxt.diag_val = pwdata[rcc_pkg::DIAG_W-1:0];
                end
                default: begin
                    st_nxt.em_base = st_r.em_base;
                end
            endcase
        end

        // hardware sets win over software clears
        if (lp_set) begin
            st_nxt.lp_seen = 1'b1; // R3
        end
        if (err_event) begin
            st_nxt.err_flag = 1'b1; // R11
        end

        // deep sleep permission sequence on low-power clock edges
        case (st_r.slp)
            rcc_pkg::RCC_SLP_IDLE: begin
                st_nxt.lp_cnt = '0;
                if (st_r.deep_sleep_on) begin
                    st_nxt.slp = rcc_pkg::RCC_SLP_COUNT; // R1
                end
            end
            rcc_pkg::RCC_SLP_COUNT: begin
                if (!st_nxt.deep_sleep_on) begin
                    st_nxt.slp = rcc_pkg::RCC_SLP_IDLE;
                end else if (lp_edge) begin
                    st_nxt.lp_cnt = cnt_inc;
                    if (cnt_inc == rcc_pkg::PD_LP_EDGES) begin
                        st_nxt.slp    = rcc_pkg::RCC_SLP_PERMIT;
                        st_nxt.permit = 1'b1; // R1
                    end
                end
            end
            rcc_pkg::RCC_SLP_PERMIT: begin
                st_nxt.permit = 1'b1;
            end
            default: begin
                st_nxt.slp = rcc_pkg::RCC_SLP_IDLE;
            end
        endcase

        // wake-up ends the sleep request whatever the state
        if (sleep_exit_irq) begin
            st_nxt.slp           = rcc_pkg::RCC_SLP_IDLE;
            st_nxt.permit        = 1'b0; // R2
            st_nxt.deep_sleep_on = 1'b0;
            st_nxt.lp_cnt        = '0;
        end

        // sticky events, set wins over write-one clear
        evt[rcc_pkg::EVT_ERR]    = err_event;
        evt[rcc_pkg::EVT_LP]     = lp_set;
        evt[rcc_pkg::EVT_PERMIT] = st_nxt.permit & ~st_r.permit;
        evt[rcc_pkg::EVT_WAKE]   = sleep_exit_irq;
        st_nxt.evt_stat          = st_nxt.evt_stat | evt;
        st_nxt.irq               = |(st_r.evt_stat & st_r.evt_mask);

        st_nxt.clk_src  = core_clock_source_stat; // R6
        st_nxt.err_irq  = st_r.err_flag & st_r.err_mask; // R8 R9
        st_nxt.diag_out = st_r.diag_ovr ? st_r.diag_val : core_diag_port; // R7
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                 = st_r.prdata;
    assign pready                 = st_r.pready;
    assign pslverr                = st_r.pslverr;
    assign diag_out               = st_r.diag_out;
    assign powerdown_permit       = st_r.permit;
    assign core_error_irq         = st_r.err_irq;
    assign irq                    = st_r.irq;
    assign exchange_mem_base_addr = {15'h0000, st_r.em_base, 10'h000}; // R12 R13

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    chk_mask_reset_one: assert property ( // R8
        disable iff (1'b0) sys_rst |=> st_r.err_mask)
        else $error("error mask not one after reset");

    chk_err_irq_level: assert property ( // R9
        (st_r.err_flag && st_r.err_mask) |=> core_error_irq)
        else $error("error irq missing while flag and mask set");

    chk_err_irq_masked: assert property ( // R8
        !st_r.err_mask |=> !core_error_irq)
        else $error("error irq raised while masked");

    chk_ack_clears_flag: assert property ( // R10
        (wr_done && paddr == rcc_pkg::ADDR_CTRL_STAT && pwdata[rcc_pkg::CS_ERR_ACK] && !err_event)
        |=> !st_r.err_flag ##1 !core_error_irq)
        else $error("acknowledge did not clear error flag");

    chk_err_sets_flag: assert property ( // R11
        err_event |=> st_r.err_flag ##1 (st_r.err_flag
            || $past(wr_done && paddr == rcc_pkg::ADDR_CTRL_STAT && pwdata[rcc_pkg::CS_ERR_ACK])))
        else $error("access error did not set flag");

    chk_lp_set_only: assert property ( // R4
        (!st_r.lp_seen && !lp_set) |=> !st_r.lp_seen)
        else $error("monitor flag set without lp clock edge");

    chk_permit_hold: assert property ( // R1
        (powerdown_permit && !sleep_exit_irq) |=> powerdown_permit)
        else $error("permit dropped before sleep exit");

    chk_lp_edge_sets: assert property ( // R3
        lp_set |=> st_r.lp_seen)
        else $error("lp clock edge did not set monitor flag");

    chk_lp_reset_blocks: assert property ( // R4 R5
        (!st_r.lp_seen && lp_timer_reset) |=> !st_r.lp_seen)
        else $error("monitor flag set during lp timer reset");

    chk_permit_clears: assert property ( // R2
        sleep_exit_irq |=> !powerdown_permit && st_r.slp == rcc_pkg::RCC_SLP_IDLE)
        else $error("sleep exit did not clear permit");

    chk_permit_rise_seq: assert property ( // R1
        $rose(powerdown_permit) |-> $past(st_r.slp) == rcc_pkg::RCC_SLP_COUNT
            && $past(lp_edge) && $past(cnt_inc) == rcc_pkg::PD_LP_EDGES)
        else $error("permit raised outside the lp sequence");

    chk_clk_src_stat: assert property ( // R6
        ##1 st_r.clk_src == $past(core_clock_source_stat))
        else $error("clock source status not tracking");

    chk_diag_override: assert property ( // R7
        st_r.diag_ovr |=> diag_out == $past(st_r.diag_val))
        else $error("diagnostic output not overruled");

    chk_diag_pass: assert property ( // R7
        !st_r.diag_ovr |=> diag_out == $past(core_diag_port))
        else $error("diagnostic output not passed through");

    chk_base_reserved: assert property ( // R12 R13
        (pready && !pslverr && paddr == rcc_pkg::ADDR_EM_BASE && !pwrite)
        |-> prdata[31:17] == 15'h0000 && prdata[9:0] == 10'h000)
        else $error("base register reserved bits not zero");

    chk_ack_reads_zero: assert property ( // R10
        (pready && paddr == rcc_pkg::ADDR_CTRL_STAT && !pwrite)
        |-> !prdata[rcc_pkg::CS_ERR_ACK] && prdata[5:4] == 2'h0)
        else $error("acknowledge bit read back nonzero");

endmodule

/* verif/rcc_top_tb.sv */
`timescale 1ns/1ps
module rcc_top_tb;
    // clock, reset and bus
    logic        core_clk;
    logic        sys_rst;
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // core side
    logic        lp_clk;
    logic        lp_timer_reset;
    logic        core_clock_source_stat;
    logic        sleep_exit_irq;
    logic        em_acc_valid;
    logic [5:0]  em_acc_page;
    logic [5:0]  em_page_map;
    logic [7:0]  core_diag_port;
    logic [7:0]  diag_out;
    logic        powerdown_permit;
    logic        core_error_irq;
    logic        irq;
    logic [31:0] exchange_mem_base_addr;
    // bench state and model
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [31:0] rdv;
    logic        errv;
    logic [31:0] wv;
    logic        m_msk;
    logic        m_ovr;
    logic        m_flag;
    logic        m_lp;
    logic        m_pd;
    logic [31:0] m_q[$];

    localparam logic [31:0] CS = rcc_pkg::ADDR_CTRL_STAT;
    localparam logic [31:0] EB = rcc_pkg::ADDR_EM_BASE;

    rcc_top u_rcc_top (
        .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lp_clk(lp_clk), .lp_timer_reset(lp_timer_reset), .core_clock_source_stat(core_clock_source_stat),
        .sleep_exit_irq(sleep_exit_irq), .em_acc_valid(em_acc_valid), .em_acc_page(em_acc_page),
        .em_page_map(em_page_map), .core_diag_port(core_diag_port), .diag_out(diag_out),
        .powerdown_permit(powerdown_permit), .core_error_irq(core_error_irq), .irq(irq),
        .exchange_mem_base_addr(exchange_mem_base_addr)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(logic [31:0] a, logic w, logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) begin
            mismatches++;
            $display("[ERR] pready expected 1 seen none");
        end
    endtask

    task automatic wr(logic [31:0] a, logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(logic [31:0] a, logic [31:0] e, string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rdv);
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic lp_pulse();
        lp_clk <= 1'b1;
        cyc(4);
        lp_clk <= 1'b0;
        cyc(4);
    endtask

    task automatic em_access(logic [5:0] p);
        em_acc_valid <= 1'b1;
        em_acc_page  <= p;
        @(posedge core_clk);
        em_acc_valid <= 1'b0;
    endtask

    function automatic logic [31:0] cs_exp();
        return {23'h0, m_pd, m_lp, core_clock_source_stat, 2'b00, m_ovr, m_msk, 1'b0, m_flag};
    endfunction

    // write image of the control register; reserved bits written as ones
    function automatic logic [31:0] cs_wr(logic keep_lp, logic ack);
        return {24'hffff_ff, keep_lp, 3'b111, m_ovr, m_msk, ack, 1'b1};
    endfunction

    initial begin
        sys_rst = 1'b1;
        paddr = 32'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        lp_clk = 1'b0;
        lp_timer_reset = 1'b0;
        core_clock_source_stat = 1'b0;
        sleep_exit_irq = 1'b0;
        em_acc_valid = 1'b0;
        em_acc_page = 6'h00;
        em_page_map = 6'h20;
        core_diag_port = 8'h00;
        {m_ovr, m_flag, m_lp, m_pd} = 4'h0;
        m_msk = 1'b1;
        void'($urandom(32'hb24f));
        cyc(8);
        sys_rst <= 1'b0;
        rd(CS, cs_exp(), "ctrl_reset");
        rd(EB, 32'h0, "base_reset");
        for (int i = 0; i < 2; i++) begin
            core_clock_source_stat <= i[0];
            cyc(2);
            rd(CS, cs_exp(), "clk_src");
        end
        for (int i = 0; i < 5; i++) begin
            wv = (i == 0) ? 32'hffff_ffff : $urandom();
            m_q.push_back(wv & 32'h0001_fc00);
            wr(EB, wv);
            rd(EB, m_q[$], "base_rd");
            chk("base_out", m_q.pop_front(), exchange_mem_base_addr);
        end
        wr(32'h4000_0204, 32'hffff_ffff);
        chk("slverr", 32'h1, 32'(errv));
        wr(rcc_pkg::ADDR_DIAG_VAL, 32'h0000_00a5);
        m_ovr = 1'b1;
        wr(CS, cs_wr(1'b1, 1'b0));
        core_diag_port <= 8'($urandom());
        cyc(2);
        chk("diag_ovr", 32'ha5, 32'(diag_out));
        rd(CS, cs_exp(), "ctrl_ovr");
        m_ovr = 1'b0;
        wr(CS, cs_wr(1'b1, 1'b0));
        core_diag_port <= 8'($urandom());
        cyc(2);
        chk("diag_pass", 32'(core_diag_port), 32'(diag_out));
        wr(rcc_pkg::ADDR_EVT_STAT, 32'hf);
        wr(rcc_pkg::ADDR_EVT_MASK, 32'h1);
        em_access(6'h20);
        cyc(3);
        chk("err_irq_mapped", 32'h0, 32'(core_error_irq));
        em_access(6'h21);
        cyc(3);
        m_flag = 1'b1;
        chk("err_irq", 32'h1, 32'(core_error_irq));
        chk("irq", 32'h1, 32'(irq));
        rd(CS, cs_exp(), "err_flag");
        m_msk = 1'b0;
        wr(CS, cs_wr(1'b1, 1'b0));
        cyc(2);
        chk("err_irq_masked", 32'h0, 32'(core_error_irq));
        rd(CS, cs_exp(), "ack_zero");
        m_msk = 1'b1;
        cyc(2);
        wr(CS, cs_wr(1'b1, 1'b0));
        cyc(2);
        chk("err_irq_level", 32'h1, 32'(core_error_irq));
        wr(CS, cs_wr(1'b1, 1'b1));
        m_flag = 1'b0;
        cyc(2);
        chk("err_irq_ack", 32'h0, 32'(core_error_irq));
        rd(CS, cs_exp(), "ack_reads0");
        wr(rcc_pkg::ADDR_EVT_STAT, 32'h1);
        cyc(2);
        chk("irq_clear", 32'h0, 32'(irq));
        wr(rcc_pkg::ADDR_EVT_MASK, 32'h0);
        em_access(6'h3f);
        cyc(3);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(rcc_pkg::ADDR_EVT_STAT, 1'b0, 32'h0);
        chk("evt_err", 32'h1, rdv & 32'h1);
        wr(CS, cs_wr(1'b1, 1'b1));
        lp_pulse();
        m_lp = 1'b1;
        rd(CS, cs_exp(), "lp_seen");
        wr(CS, cs_wr(1'b1, 1'b0));
        rd(CS, cs_exp(), "lp_write1");
        m_lp = 1'b0;
        wr(CS, cs_wr(1'b0, 1'b0));
        rd(CS, cs_exp(), "lp_write0");
        wr(CS, cs_wr(1'b1, 1'b0));
        rd(CS, cs_exp(), "lp_write1_idle");
        lp_timer_reset <= 1'b1;
        lp_pulse();
        rd(CS, cs_exp(), "lp_in_reset");
        lp_timer_reset <= 1'b0;
        cyc(2);
        // request withdrawn while counting: no permit afterwards
        wr(rcc_pkg::ADDR_SLEEP_CTL, 32'h1);
        lp_pulse();
        wr(rcc_pkg::ADDR_SLEEP_CTL, 32'h0);
        repeat (rcc_pkg::PD_LP_EDGES) lp_pulse();
        m_lp = 1'b1;
        chk("permit_abort", 32'h0, 32'(powerdown_permit));
        wr(rcc_pkg::ADDR_SLEEP_CTL, 32'h1);
        repeat (rcc_pkg::PD_LP_EDGES - 1) lp_pulse();
        m_lp = 1'b1;
        chk("permit_early", 32'h0, 32'(powerdown_permit));
        lp_pulse();
        m_pd = 1'b1;
        chk("permit", 32'h1, 32'(powerdown_permit));
        rd(CS, cs_exp(), "ctrl_permit");
        sleep_exit_irq <= 1'b1;
        @(posedge core_clk);
        sleep_exit_irq <= 1'b0;
        cyc(2);
        m_pd = 1'b0;
        chk("permit_exit", 32'h0, 32'(powerdown_permit));
        rd(CS, cs_exp(), "ctrl_exit");
        rd(rcc_pkg::ADDR_EVT_STAT, 32'hf, "evt_all");
        test_done();
    end
endmodule
